// ==== rtl/sfpr_readout.sv ====
// Purpose: Sample FIFO and pace edge readback over a serial register port, with both interrupts.
// Assumes: Serial link mode 0, command byte {addr[6:0], read}, eight idle bits, then 24 data bits.
// Notes: The idle bits give the core time to fetch the word across the clock boundary.
`include "sfpr_cfg.svh"

// Overview of operation
// - Pace interrupt rises on a completed pace group, regardless of FIFO fill.
// - Sample interrupt stays low until stored samples reach the programmed threshold.
// - Sample tag reflects FIFO fill when read; host decodes tags per word.
// - FIFO word is sample in bits 23:6, sample tag 5:3, pace tag 2:0.
// - Reading an empty FIFO returns zero sample with the empty tag.
// - Pace words hold two segments of timing plus direction and last flags.
// - Unused edge slots read as all-ones timing with both flags set.
// - Samples and pace words are fetched by ordinary serial register reads.
module sfpr_readout
  import sfpr_pkg::*;
#(
  parameter int DEPTH_LOG2 = 5
) (
  input wire logic core_clk, // Core clock, 25 MHz.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic ce, // Clock enable for all core state.
  input wire logic sclk, // Serial link clock from the host.
  input wire logic csb_n, // Serial frame select, active low.
  input wire logic sdi, // Serial data from the host.
  output logic sdo, // Serial data to the host.
  output logic sdo_oe_n, // Low while sdo is driven.
  input wire logic sample_valid, // New sample offered.
  input wire logic [17:0] sample_data, // Sample value.
  input wire logic [2:0] sample_pace_tag, // Pace tag travelling with the sample.
  output logic sample_ready, // FIFO has room.
  input wire logic pace_edge_valid, // New pace edge offered.
  input wire logic pace_edge_group, // Group of the edge, 0 or 1.
  input wire logic [9:0] pace_edge_time, // Edge timing value.
  input wire logic edge_direction_flag, // Edge direction.
  input wire logic last_edge_flag, // Edge closes its group.
  input wire logic [DEPTH_LOG2:0] buffer_irq_threshold, // Sample interrupt threshold.
  output logic pace_event_irq, // Pace interrupt, active high level.
  output logic sample_buffer_irq // Sample interrupt, active high level.
);
  localparam int DEPTH = 1 << DEPTH_LOG2;

  // ---------------- Link domain ----------------
  logic spi_rst_n;
  logic [5:0] bit_cnt_q;
  logic [7:0] cmd_q;
  logic [6:0] addr_q;
  logic req_q;
  logic ack_s1_q, ack_s2_q;
  logic word_ok_q;
  logic [23:0] sh_q;
  logic ack_q;
  logic [23:0] rd_word_q;

  // Frame logic restarts whenever select is high; the link clock may be still then.
  assign spi_rst_n = rst_n & ~csb_n;

  // Bit counter and command shift on rising edges.
  always_ff @(posedge sclk or negedge spi_rst_n) begin
    if (!spi_rst_n) begin
      bit_cnt_q <= 6'h00;
      cmd_q <= 8'h00;
    end else begin
      if (bit_cnt_q != `SFPR_CNT_END) begin
        bit_cnt_q <= bit_cnt_q + 6'h01;
      end
      if (bit_cnt_q <= `SFPR_CNT_CMD) begin
        cmd_q <= {cmd_q[6:0], sdi};
      end
    end
  end

  // Read request toggles once the command byte is in; it must survive frames.
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      req_q <= 1'b0;
      addr_q <= 7'h00;
    end else if (!csb_n && bit_cnt_q == `SFPR_CNT_CMD && sdi) begin
      req_q <= ~req_q;
      addr_q <= cmd_q[6:0];
    end
  end

  // Acknowledge synchroniser into the link domain.
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
    end else begin
      ack_s1_q <= ack_q;
      ack_s2_q <= ack_s1_q;
    end
  end

  // The word is only trusted when the core has answered this request.
  always_ff @(posedge sclk or negedge spi_rst_n) begin
    if (!spi_rst_n) begin
      word_ok_q <= 1'b0;
    end else if (bit_cnt_q == `SFPR_CNT_ACK) begin
      word_ok_q <= (ack_s2_q == req_q);
    end
  end

  // Data shifts out on falling edges so the host samples on rising ones.
  always_ff @(negedge sclk or negedge spi_rst_n) begin
    if (!spi_rst_n) begin
      sh_q <= 24'h000000;
    end else if (bit_cnt_q == `SFPR_CNT_DATA) begin
      sh_q <= word_ok_q ? rd_word_q : 24'h000000;
    end else if (bit_cnt_q > `SFPR_CNT_DATA) begin
      sh_q <= {sh_q[22:0], 1'b0};
    end
  end

  assign sdo = sh_q[23];
  assign sdo_oe_n = csb_n;

  // ---------------- Core domain ----------------
  sfpr_state_t state_q;
  logic req_s1_q, req_s2_q, req_seen_q;
  logic new_req;
  logic [DEPTH_LOG2:0] fill_q;
  logic [DEPTH_LOG2-1:0] wr_ptr_q, rd_ptr_q;
  logic push, pop;
  logic [2:0] tag_q;
  logic [20:0] mem_rdata;
  logic [11:0] seg_q [0:11];
  logic [2:0] slot_q [0:1];
  logic [1:0] done_q;
  logic pace_clr;

  // Reads a pair of segments as one pace word.
  function automatic logic [23:0] pace_word(input logic grp, input logic [1:0] idx);
    logic [3:0] base;
    base = {3'h0, grp} * 4'h6 + {1'b0, idx, 1'b0};
    return {seg_q[base], seg_q[base + 4'h1]};
  endfunction

  // Address decode for the six pace words.
  function automatic logic [23:0] decode_read(input logic [6:0] a);
    case (a)
      `SFPR_ADDR_P1A: decode_read = pace_word(1'b0, 2'h0);
      `SFPR_ADDR_P1B: decode_read = pace_word(1'b0, 2'h1);
      `SFPR_ADDR_P1C: decode_read = pace_word(1'b0, 2'h2);
      `SFPR_ADDR_P2A: decode_read = pace_word(1'b1, 2'h0);
      `SFPR_ADDR_P2B: decode_read = pace_word(1'b1, 2'h1);
      `SFPR_ADDR_P2C: decode_read = pace_word(1'b1, 2'h2);
      default: decode_read = 24'h000000;
    endcase
  endfunction

  // Request toggle synchroniser; only the second stage is read.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
    end else if (ce) begin
      req_s1_q <= req_q;
      req_s2_q <= req_s1_q;
    end
  end

  assign new_req = (req_s2_q != req_seen_q) && state_q == SFPR_IDLE;
  assign sample_ready = fill_q != DEPTH[DEPTH_LOG2:0];
  assign push = sample_valid && sample_ready;
  assign pop = new_req && addr_q == `SFPR_ADDR_FIFO && fill_q != '0;
  assign pace_clr = new_req && (addr_q inside {`SFPR_ADDR_P1A, `SFPR_ADDR_P1B, `SFPR_ADDR_P1C,
    `SFPR_ADDR_P2A, `SFPR_ADDR_P2B, `SFPR_ADDR_P2C});

  // Sample store; pace tag travels with each sample.
  sfpr_mem #(
    .WIDTH(21),
    .AW(DEPTH_LOG2)
  ) u_mem (
    .core_clk(core_clk),
    .ce(ce),
    .wr_en(push),
    .wr_addr(wr_ptr_q),
    .wr_data({sample_data, sample_pace_tag}),
    .rd_en(pop),
    .rd_addr(rd_ptr_q),
    .rd_data(mem_rdata)
  );

  // FIFO pointers and fill count.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      fill_q <= '0;
    end else if (ce) begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      fill_q <= fill_q + {{DEPTH_LOG2{1'b0}}, push} - {{DEPTH_LOG2{1'b0}}, pop};
    end
  end

  // Sample interrupt follows the fill level against the threshold.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_buffer_irq <= 1'b0;
    end else if (ce) begin
      sample_buffer_irq <= fill_q >= buffer_irq_threshold;
    end
  end

  // Read sequencer: fetch, build the word, then answer the link.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= SFPR_IDLE;
      req_seen_q <= 1'b0;
      ack_q <= 1'b0;
      tag_q <= `SFPR_TAG_VALID;
      rd_word_q <= 24'h000000;
    end else if (ce) begin
      case (state_q)
        SFPR_IDLE: begin
          if (new_req) begin
            req_seen_q <= req_s2_q;
            if (pop) begin
              // The last stored sample is marked so the host can stop early.
              tag_q <= (fill_q == 1) ? `SFPR_TAG_LAST : `SFPR_TAG_VALID;
              state_q <= SFPR_FETCH;
            end else if (addr_q == `SFPR_ADDR_FIFO) begin
              rd_word_q <= {`SFPR_SAMPLE_EMPTY, `SFPR_TAG_EMPTY, `SFPR_PACE_TAG_NONE};
              state_q <= SFPR_DONE;
            end else begin
              rd_word_q <= decode_read(addr_q);
              state_q <= SFPR_DONE;
            end
          end
        end
        SFPR_FETCH: begin
          rd_word_q <= {mem_rdata[20:3], tag_q, mem_rdata[2:0]};
          state_q <= SFPR_DONE;
        end
        SFPR_DONE: begin
          ack_q <= req_seen_q;
          state_q <= SFPR_IDLE;
        end
        default: state_q <= SFPR_IDLE;
      endcase
    end
  end

  // Pace edge capture; a new edge after a closed group restarts that group.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 12; i++) begin
        seg_q[i] <= `SFPR_SEG_UNUSED;
      end
      slot_q[0] <= 3'h0;
      slot_q[1] <= 3'h0;
      done_q <= 2'h0;
    end else if (ce && pace_edge_valid) begin
      if (done_q[pace_edge_group]) begin
        for (int i = 0; i < 6; i++) begin
          seg_q[{3'h0, pace_edge_group} * 4'h6 + 4'(i)] <= `SFPR_SEG_UNUSED;
        end
        seg_q[{3'h0, pace_edge_group} * 4'h6] <=
          {pace_edge_time, edge_direction_flag, last_edge_flag};
        slot_q[pace_edge_group] <= 3'h1;
      end else if (slot_q[pace_edge_group] != `SFPR_SLOTS) begin
        // A seventh edge has no slot and is dropped.
        seg_q[{3'h0, pace_edge_group} * 4'h6 + {1'b0, slot_q[pace_edge_group]}] <=
          {pace_edge_time, edge_direction_flag, last_edge_flag};
        slot_q[pace_edge_group] <= slot_q[pace_edge_group] + 3'h1;
      end
      done_q[pace_edge_group] <= last_edge_flag;
    end
  end

  // Pace interrupt: a closed group sets it; a pace read clears it, and a set wins.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pace_event_irq <= 1'b0;
    end else if (ce) begin
      if (pace_edge_valid && last_edge_flag) begin
        pace_event_irq <= 1'b1;
      end else if (pace_clr) begin
        pace_event_irq <= 1'b0;
      end
    end
  end

  // ---------------- Checks ----------------
  a_pace_irq_set: assert property (@(posedge core_clk) disable iff (!rst_n)
    ce && pace_edge_valid && last_edge_flag |=> pace_event_irq)
    else $error("Pace interrupt missed a closed group.");

  a_buf_irq_low: assert property (@(posedge core_clk) disable iff (!rst_n)
    ce && fill_q < buffer_irq_threshold |=> !sample_buffer_irq)
    else $error("Sample interrupt raised below threshold.");

  a_buf_irq_high: assert property (@(posedge core_clk) disable iff (!rst_n)
    ce && fill_q >= buffer_irq_threshold |=> sample_buffer_irq)
    else $error("Sample interrupt missing at threshold.");

  a_last_tag: assert property (@(posedge core_clk) disable iff (!rst_n)
    ce && pop && fill_q == 1 ##1 ce |=> rd_word_q[5:3] == `SFPR_TAG_LAST)
    else $error("Last sample not tagged as last.");

  a_word_layout: assert property (@(posedge core_clk) disable iff (!rst_n)
    ce && state_q == SFPR_FETCH |=> rd_word_q[23:6] == $past(mem_rdata[20:3])
      && rd_word_q[2:0] == $past(mem_rdata[2:0]))
    else $error("Sample word fields misplaced.");

  a_empty_word: assert property (@(posedge core_clk) disable iff (!rst_n)
    ce && new_req && addr_q == `SFPR_ADDR_FIFO && fill_q == 0 |=>
      rd_word_q == {`SFPR_SAMPLE_EMPTY, `SFPR_TAG_EMPTY, `SFPR_PACE_TAG_NONE})
    else $error("Empty read returned wrong word.");

  a_pace_word: assert property (@(posedge core_clk) disable iff (!rst_n)
    ce && new_req && addr_q == `SFPR_ADDR_P2A && !pace_edge_valid |=>
      rd_word_q == {$past(seg_q[6]), $past(seg_q[7])})
    else $error("Group two word a misread.");

  a_unused_slot: assert property (@(posedge core_clk) disable iff (!rst_n)
    ce && pace_edge_valid && done_q[0] && !pace_edge_group |=>
      seg_q[5] == `SFPR_SEG_UNUSED && slot_q[0] == 3'h1)
    else $error("Restarted group kept stale slots.");

  a_answer_time: assert property (@(posedge core_clk) disable iff (!rst_n)
    ce && new_req |-> ##[1:6] (ack_q == req_seen_q && state_q == SFPR_IDLE))
    else $error("Read not answered in time.");

  a_sdo_frame: assert property (@(posedge sclk) disable iff (!rst_n)
    bit_cnt_q < `SFPR_CNT_DATA |-> !sdo && !sdo_oe_n)
    else $error("Serial output not quiet and driven before the data bits.");
endmodule

// ==== rtl/sfpr_cfg.svh ====
// Purpose: Named constants for the sample FIFO and pace readout block.
// Assumes: Seven-bit register addresses and 24-bit read words.
// Notes: Included by the readout module and by the bench, the files that decode words.
`ifndef SFPR_CFG_SVH
`define SFPR_CFG_SVH
`define SFPR_ADDR_FIFO 7'h21
`define SFPR_ADDR_P1A 7'h35
`define SFPR_ADDR_P1B 7'h36
`define SFPR_ADDR_P1C 7'h37
`define SFPR_ADDR_P2A 7'h39
`define SFPR_ADDR_P2B 7'h3A
`define SFPR_ADDR_P2C 7'h3B
`define SFPR_TAG_VALID 3'h0
`define SFPR_TAG_LAST 3'h2
`define SFPR_TAG_EMPTY 3'h6
`define SFPR_PACE_TAG_NONE 3'h7
`define SFPR_SAMPLE_EMPTY 18'h00000
`define SFPR_SEG_UNUSED 12'hFFF
`define SFPR_CNT_CMD 6'h07
`define SFPR_CNT_ACK 6'h0F
`define SFPR_CNT_DATA 6'h10
`define SFPR_CNT_END 6'h28
`define SFPR_SLOTS 3'h6
`endif

// ==== rtl/sfpr_pkg.sv ====
// Purpose: Types shared by the sample FIFO and pace readout block.
// Assumes: Nothing beyond the constants header.
// Notes: States use Gray codes along the fetch path.
package sfpr_pkg;
  typedef enum logic [1:0] {
    SFPR_IDLE = 2'h0,
    SFPR_FETCH = 2'h1,
    SFPR_DONE = 2'h3
  } sfpr_state_t;
endpackage

// ==== rtl/sfpr_mem.sv ====
// Purpose: Storage for buffered sample words with a registered read port.
// Assumes: One write and one read port on the core clock.
// Notes: Read data appear one enabled edge after the read request.
module sfpr_mem #(
  parameter int WIDTH = 21,
  parameter int AW = 5
) (
  input wire logic core_clk, // Core clock.
  input wire logic ce, // Clock enable; state holds while low.
  input wire logic wr_en, // Write strobe.
  input wire logic [AW-1:0] wr_addr, // Write address.
  input wire logic [WIDTH-1:0] wr_data, // Write data.
  input wire logic rd_en, // Read strobe.
  input wire logic [AW-1:0] rd_addr, // Read address.
  output logic [WIDTH-1:0] rd_data // Registered read data.
);
  logic [WIDTH-1:0] mem_q [0:(1<<AW)-1];

  // Write port; no reset, contents are only read after being written.
  always_ff @(posedge core_clk) begin
    if (ce && wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  // Read port registered so the fetch path has a full cycle.
  always_ff @(posedge core_clk) begin
    if (ce && rd_en) begin
      rd_data <= mem_q[rd_addr];
    end
  end
endmodule

// ==== testbench/sfpr_host_model.sv ====
// Purpose: Serial host that reads one register word per frame from the readout block.
// Assumes: Mode 0 link, command byte {addr, read}, eight idle bits, then 24 data bits.
// Notes: The link clock stands low between frames and runs only inside a frame.
module sfpr_host_model (
  output logic sclk, // Link clock, 64 ns period inside frames.
  output logic csb_n, // Frame select, active low.
  output logic sdi, // Command bits to the device.
  input wire logic sdo // Data bits from the device.
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle link at time zero.
  initial begin
    sclk = 1'b0;
    csb_n = 1'b1;
    sdi = 1'b0;
  end

  // One read frame; idle bits toggle sdi so the device cannot rely on a held level.
  task automatic read_word(input logic [6:0] addr, output logic [23:0] word);
    logic [7:0] cmd;
    int i;
    cmd = {addr, 1'b1};
    word = 24'h000000;
    #9;
    csb_n = 1'b0;
    for (i = 0; i < 40; i++) begin
      if (i < 8) sdi = cmd[7-i];
      else sdi = ~sdi;
      #32;
      sclk = 1'b1;
      if (i >= 16) word = {word[22:0], sdo};
      #32;
      sclk = 1'b0;
    end
    #32;
    csb_n = 1'b1;
    sdi = ~sdi;
    #64;
  endtask
endmodule

// ==== testbench/sfpr_readout_bench.sv ====
// Purpose: Self-checking bench for sample FIFO and pace edge readback.
// Assumes: Eight-word FIFO and a threshold of eight samples.
// Notes: Expected words come from queues and arrays kept by the bench itself.
`include "sfpr_cfg.svh"
module sfpr_readout_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int DL = 3;
  logic core_clk, rst_n, ce, sample_valid, pace_edge_valid, pace_edge_group;
  logic edge_direction_flag, last_edge_flag;
  logic [17:0] sample_data;
  logic [2:0] sample_pace_tag;
  logic [9:0] pace_edge_time;
  logic [DL:0] buffer_irq_threshold;
  wire logic sclk, csb_n, sdi, sdo, sdo_oe_n, sample_ready, pace_event_irq, sample_buffer_irq;
  int err_total, n_checks, seed, i;
  logic [20:0] q[$];
  logic [23:0] w;
  logic [11:0] pg[2][6];
  int pc[2];
  bit rs[2];
  logic [6:0] pa[6];

  sfpr_readout #(.DEPTH_LOG2(DL)) dut (.core_clk(core_clk), .rst_n(rst_n), .ce(ce),
    .sclk(sclk), .csb_n(csb_n), .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
    .sample_valid(sample_valid), .sample_data(sample_data), .sample_pace_tag(sample_pace_tag),
    .sample_ready(sample_ready), .pace_edge_valid(pace_edge_valid),
    .pace_edge_group(pace_edge_group), .pace_edge_time(pace_edge_time),
    .edge_direction_flag(edge_direction_flag), .last_edge_flag(last_edge_flag),
    .buffer_irq_threshold(buffer_irq_threshold), .pace_event_irq(pace_event_irq),
    .sample_buffer_irq(sample_buffer_irq));
  sfpr_host_model host (.sclk(sclk), .csb_n(csb_n), .sdi(sdi), .sdo(sdo));

  // Core clock at 25 MHz.
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Offer one sample; the bench keeps it only when the FIFO had room.
  task automatic push(input logic [17:0] d, input logic [2:0] t);
    logic ok;
    @(negedge core_clk);
    sample_valid = 1'b1;
    sample_data = d;
    sample_pace_tag = t;
    ok = sample_ready;
    @(negedge core_clk);
    sample_valid = 1'b0;
    if (ok === 1'b1) q.push_back({d, t});
  endtask

  // One pace edge strobe, mirrored into the bench's slot arrays.
  task automatic edge_in(input int g, input logic [9:0] t, input logic l);
    logic d;
    d = $random(seed);
    @(negedge core_clk);
    pace_edge_valid = 1'b1;
    pace_edge_group = g[0];
    pace_edge_time = t;
    edge_direction_flag = d;
    last_edge_flag = l;
    @(negedge core_clk);
    pace_edge_valid = 1'b0;
    if (rs[g]) begin
      for (int k = 0; k < 6; k++) pg[g][k] = 12'hFFF;
      pc[g] = 0;
    end
    if (pc[g] < 6) pg[g][pc[g]] = {t, d, l};
    if (pc[g] < 6) pc[g]++;
    rs[g] = l;
  endtask

  // Pop one word; the tag says last when it was the only stored sample.
  task automatic read_fifo();
    logic [20:0] e;
    host.read_word(`SFPR_ADDR_FIFO, w);
    if (q.size() == 0) begin
      chk("fifo empty", w, {`SFPR_SAMPLE_EMPTY, `SFPR_TAG_EMPTY, `SFPR_PACE_TAG_NONE});
    end else begin
      e = q.pop_front();
      chk("fifo", w, {e[20:3], (q.size() == 0) ? `SFPR_TAG_LAST : `SFPR_TAG_VALID, e[2:0]});
    end
  endtask

  task automatic read_pace();
    int k;
    for (k = 0; k < 6; k++) begin
      host.read_word(pa[k], w);
      chk("pace word", w, {pg[k/3][(k%3)*2], pg[k/3][(k%3)*2+1]});
    end
  endtask

  task automatic chk_irq();
    repeat (2) @(negedge core_clk);
    chk("sample irq", sample_buffer_irq, q.size() >= 8);
    chk("ready", sample_ready, q.size() < 8);
  endtask

  // Watchdog: a hang counts as a mismatch.
  initial begin
    repeat (90000) @(posedge core_clk);
    err_total++;
    print_verdict();
  end

  // Main sequence.
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    sample_valid = 1'b0;
    sample_data = 18'h00000;
    sample_pace_tag = 3'h0;
    pace_edge_valid = 1'b0;
    pace_edge_group = 1'b0;
    pace_edge_time = 10'h000;
    edge_direction_flag = 1'b0;
    last_edge_flag = 1'b0;
    buffer_irq_threshold = 4'h8;
    err_total = 0;
    n_checks = 0;
    seed = 10;
    pa = '{`SFPR_ADDR_P1A, `SFPR_ADDR_P1B, `SFPR_ADDR_P1C,
      `SFPR_ADDR_P2A, `SFPR_ADDR_P2B, `SFPR_ADDR_P2C};
    foreach (pg[a, b]) pg[a][b] = 12'hFFF;
    repeat (16) @(negedge core_clk);
    rst_n = 1'b1;
    chk("oe", sdo_oe_n, csb_n);
    chk("pace irq", pace_event_irq, 1'b0);
    chk_irq();
    read_fifo();
    read_pace();
    host.read_word(7'h22, w);
    chk("unmapped", w, 24'h000000);
    $display("test reset done");
    // Pace events must interrupt while the FIFO is below threshold.
    for (i = 0; i < 3; i++) push($random(seed), $random(seed));
    edge_in(0, 10'h100, 1'b0);
    edge_in(0, $random(seed), 1'b0);
    edge_in(0, 10'h3FF, 1'b1);
    edge_in(1, 10'h0A0, 1'b1);
    repeat (2) @(negedge core_clk);
    chk("pace irq", pace_event_irq, 1'b1);
    chk_irq();
    for (i = 0; i < 4; i++) read_fifo();
    read_pace();
    chk("pace irq", pace_event_irq, 1'b0);
    $display("test pace done");
    // Fill past full, two refused offers, then drain to empty.
    for (i = 0; i < 10; i++) begin
      push((i == 0) ? 18'h3FFFF : $random(seed), $random(seed));
      chk_irq();
    end
    // Stop at the word tagged last, as a host that reads only what it needs.
    i = 0;
    do begin
      read_fifo();
      i++;
    end while (w[5:3] != `SFPR_TAG_LAST && i < 9);
    chk("drain count", i, 8);
    read_fifo();
    chk_irq();
    // Offers while the clock enable is low must not be taken.
    @(negedge core_clk);
    ce = 1'b0;
    sample_valid = 1'b1;
    repeat (3) @(negedge core_clk);
    sample_valid = 1'b0;
    ce = 1'b1;
    chk_irq();
    read_fifo();
    $display("test fill done");
    // Restart both groups, overflow group one with seven edges.
    for (i = 0; i < 7; i++) edge_in(0, $random(seed), 1'b0);
    edge_in(1, $random(seed), 1'b0);
    read_pace();
    chk("pace irq", pace_event_irq, 1'b0);
    $display("test restart done");
    print_verdict();
  end
endmodule
